// ---- hdl/cfs_regs.vh ----
/*
  Register offsets, field positions, reset values and encodings of the capture store block.
  Assumes inclusion by bare name from the design files of this block.
*/
`ifndef CFS_REGS_VH
`define CFS_REGS_VH
`define CFS_ADDR_CONTROL 16'h7420
`define CFS_ADDR_STATUS 16'h7422
`define CFS_ADDR_STORE1 16'h7423
`define CFS_ADDR_STORE2 16'h7424
`define CFS_ADDR_STORE3 16'h7425
`define CFS_ADDR_STORE4 16'h7426
`define CFS_CTRL_RESET 16'h0000
`define CFS_STATUS_RESET 8'h00
`define CFS_CTRL_SOFT_CLEAR_BIT 15
`define CFS_CTRL_PAIR12_HI 14
`define CFS_CTRL_PAIR12_LO 13
`define CFS_CTRL_EN3_BIT 12
`define CFS_CTRL_EN4_BIT 11
`define CFS_CTRL_TSEL34_BIT 10
`define CFS_CTRL_TSEL12_BIT 9
`define CFS_PAIR12_CAPTURE 2'h1
`define CFS_EDGE_NONE 2'h0
`define CFS_EDGE_RISE 2'h1
`define CFS_EDGE_FALL 2'h2
`define CFS_EDGE_BOTH 2'h3
`define CFS_FILL_EMPTY 2'h0
`define CFS_FILL_ONE 2'h1
`define CFS_FILL_TWO 2'h2
`define CFS_FILL_LOST 2'h3
`define CFS_STATUS_LSB 8
`define CFS_FIFO_DEPTH 8
`define CFS_FIFO_PTR_W 3
`endif

// ---- hdl/cfs_fifo.v ----
/*
  Synchronous FIFO with parameters for width and depth, valid and ready on both sides.
  Assumes one clock and an asynchronous active-high reset; depth is a power of two.
*/
`timescale 1ns/1ns
`default_nettype none
module cfs_fifo #(
  parameter WIDTH = 20,
  parameter DEPTH = 8,
  parameter PTR_W = 3
) (
  input wire clk_in,
  input wire rst_in,
  input wire clear_in,
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [PTR_W-1:0] wr_ptr_reg;
  reg [PTR_W-1:0] rd_ptr_reg;
  reg [PTR_W:0] count_reg;
  wire push;
  wire pop;
  integer i;

  assign in_ready_out = (count_reg != DEPTH[PTR_W:0]);
  assign out_valid_out = (count_reg != {(PTR_W+1){1'b0}});
  assign out_data_out = mem_reg[rd_ptr_reg];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wr_ptr_reg <= {PTR_W{1'b0}};
      rd_ptr_reg <= {PTR_W{1'b0}};
      count_reg <= {(PTR_W+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1)
        mem_reg[i] <= {WIDTH{1'b0}};
    end
    else if (clear_in)
    begin
      wr_ptr_reg <= {PTR_W{1'b0}};
      rd_ptr_reg <= {PTR_W{1'b0}};
      count_reg <= {(PTR_W+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        mem_reg[wr_ptr_reg] <= in_data_in;
        wr_ptr_reg <= wr_ptr_reg + {{(PTR_W-1){1'b0}}, 1'b1};
      end
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + {{(PTR_W-1){1'b0}}, 1'b1};
      if (push && !pop)
        count_reg <= count_reg + {{PTR_W{1'b0}}, 1'b1};
      else if (pop && !push)
        count_reg <= count_reg - {{PTR_W{1'b0}}, 1'b1};
    end
  end
endmodule // cfs_fifo
`default_nettype wire

// ---- hdl/cfs_capture_top.v ----
/*
  Four capture channels, each with a two-level store of timer snapshots, the control word
  and the 16-bit store status word, reached over the processor data memory port.
  Assumes capture pins and timer values synchronous to clk_in; a data read is a one-cycle
  strobe and its data is returned one cycle later on rd_data_out.
*/
`timescale 1ns/1ns
`default_nettype none
`include "cfs_regs.vh"
// Function
// - each channel has two-level top/bottom store
// - status word at 7422h, high read, low write
// - channel 4..1 in bits 15-14 down to 9-8
// - 00 empty, 01 one, 10 two, 11 lost
// - writing one at bit x clears x+8, ignored if any level changes that cycle
// - status and clear bits reset to zero
// - store read returns older top value
// - reading top shifts bottom value up
// - capture into empty fills top, status 01
// - reading single value sets status 00
// - capture with one value fills bottom, 10
// - reading two values returns top, status 01
// - capture when full drops oldest, status 11
// - enabled edge loads timer, sets flag
// - disabled channel keeps its store contents
// - soft clear or reset zeroes all capture registers
module cfs_capture_top (
  input wire clk_in,
  input wire rst_in,
  input wire [15:0] addr_in,
  input wire wr_en_in,
  input wire rd_en_in,
  input wire [15:0] wr_data_in,
  output reg [15:0] rd_data_out,
  input wire [3:0] capture_input_pin_in,
  input wire [15:0] timer2_count_in,
  input wire [15:0] timer3_count_in,
  output reg [3:0] capture_flag_out,
  output reg [3:0] fifo_drop_out
);
  // ----------------------------------------
  // Registers and declarations
  // ----------------------------------------
  reg [15:0] capture_control_word_reg;
  reg [7:0] capture_store_status_reg;
  reg [15:0] top_reg [0:3];
  reg [15:0] bottom_reg [0:3];
  reg [3:0] pin_prev_reg;
  reg pin_primed_reg;
  reg [1:0] fill_next [0:3];
  reg [15:0] top_next [0:3];
  reg [15:0] bottom_next [0:3];
  wire capture_soft_clear;
  wire [3:0] chan_enable;
  wire [3:0] edge_hit;
  wire [3:0] store_read;
  wire [19:0] fifo_in_data;
  wire fifo_in_valid;
  wire fifo_in_ready;
  wire [19:0] fifo_out_data;
  wire fifo_out_valid;
  wire [1:0] chan1_fill_level;
  wire [1:0] chan2_fill_level;
  wire [1:0] chan3_fill_level;
  wire [1:0] chan4_fill_level;
  wire [1:0] chan1_edge_select;
  integer k;
  integer j;

  // ----------------------------------------
  // Control decode
  // ----------------------------------------
  assign capture_soft_clear = ~capture_control_word_reg[`CFS_CTRL_SOFT_CLEAR_BIT];
  assign chan_enable[0] = (capture_control_word_reg[`CFS_CTRL_PAIR12_HI:`CFS_CTRL_PAIR12_LO]
    == `CFS_PAIR12_CAPTURE);
  assign chan_enable[1] = chan_enable[0];
  assign chan_enable[2] = capture_control_word_reg[`CFS_CTRL_EN3_BIT];
  assign chan_enable[3] = capture_control_word_reg[`CFS_CTRL_EN4_BIT];
  assign chan1_edge_select = capture_control_word_reg[7:6];
  assign chan4_fill_level = capture_store_status_reg[7:6];
  assign chan3_fill_level = capture_store_status_reg[5:4];
  assign chan2_fill_level = capture_store_status_reg[3:2];
  assign chan1_fill_level = capture_store_status_reg[1:0];
  assign store_read[0] = rd_en_in && (addr_in == `CFS_ADDR_STORE1);
  assign store_read[1] = rd_en_in && (addr_in == `CFS_ADDR_STORE2);
  assign store_read[2] = rd_en_in && (addr_in == `CFS_ADDR_STORE3);
  assign store_read[3] = rd_en_in && (addr_in == `CFS_ADDR_STORE4);

  // ----------------------------------------
  // Edge detection, one lane per channel
  // ----------------------------------------
  // Channel 1 uses bits 7-6 down to channel 4 at bits 1-0.
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : edge_lane
      wire [1:0] sel;
      wire rise;
      wire fall;
      assign sel = capture_control_word_reg[7-2*g:6-2*g];
      assign rise = pin_primed_reg && capture_input_pin_in[g] && !pin_prev_reg[g];
      assign fall = pin_primed_reg && !capture_input_pin_in[g] && pin_prev_reg[g];
      assign edge_hit[g] = chan_enable[g] && (
        ((sel == `CFS_EDGE_RISE) && rise) ||
        ((sel == `CFS_EDGE_FALL) && fall) ||
        ((sel == `CFS_EDGE_BOTH) && (rise || fall)));
    end
  endgenerate

  // ----------------------------------------
  // Capture event buffer
  // ----------------------------------------
  // Events wait here with their snapshot; when the buffer is full new edges are dropped
  // and fifo_drop_out reports it, which keeps the store updates one per channel per cycle.
  assign fifo_in_valid = |edge_hit;
  assign fifo_in_data[3:0] = edge_hit;
  assign fifo_in_data[19:4] = (|edge_hit[1:0]) ?
    (capture_control_word_reg[`CFS_CTRL_TSEL12_BIT] ? timer3_count_in : timer2_count_in) :
    (capture_control_word_reg[`CFS_CTRL_TSEL34_BIT] ? timer3_count_in : timer2_count_in);

  cfs_fifo #(
    .WIDTH(20),
    .DEPTH(`CFS_FIFO_DEPTH),
    .PTR_W(`CFS_FIFO_PTR_W)
  ) u_event_fifo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .clear_in(capture_soft_clear),
    .in_valid_in(fifo_in_valid),
    .in_ready_out(fifo_in_ready),
    .in_data_in(fifo_in_data),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(1'b1),
    .out_data_out(fifo_out_data)
  );

  // ----------------------------------------
  // Store next-state
  // ----------------------------------------
  // A read and a capture in the same cycle: the read pops first, then the capture pushes.
  always @*
  begin
    for (k = 0; k < 4; k = k + 1)
    begin
      top_next[k] = top_reg[k];
      bottom_next[k] = bottom_reg[k];
      fill_next[k] = capture_store_status_reg[2*k+1 -: 2];
      if (store_read[k] && (fill_next[k] != `CFS_FILL_EMPTY))
      begin
        if (fill_next[k] == `CFS_FILL_ONE)
          fill_next[k] = `CFS_FILL_EMPTY;
        else
        begin
          top_next[k] = bottom_reg[k];
          fill_next[k] = `CFS_FILL_ONE;
        end
      end
      if (fifo_out_valid && fifo_out_data[k])
      begin
        if (fill_next[k] == `CFS_FILL_EMPTY)
        begin
          top_next[k] = fifo_out_data[19:4];
          fill_next[k] = `CFS_FILL_ONE;
        end
        else if (fill_next[k] == `CFS_FILL_ONE)
        begin
          // After a pop from two, the shifted value stays on top and the capture goes below it.
          bottom_next[k] = fifo_out_data[19:4];
          fill_next[k] = `CFS_FILL_TWO;
        end
        else
        begin
          top_next[k] = bottom_reg[k];
          bottom_next[k] = fifo_out_data[19:4];
          fill_next[k] = `CFS_FILL_LOST;
        end
      end
    end
  end

  // ----------------------------------------
  // Register file and stores
  // ----------------------------------------
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      capture_control_word_reg <= `CFS_CTRL_RESET;
      capture_store_status_reg <= `CFS_STATUS_RESET;
      pin_prev_reg <= 4'h0;
      pin_primed_reg <= 1'b0;
      capture_flag_out <= 4'h0;
      fifo_drop_out <= 4'h0;
      rd_data_out <= 16'h0000;
      for (j = 0; j < 4; j = j + 1)
      begin
        top_reg[j] <= 16'h0000;
        bottom_reg[j] <= 16'h0000;
      end
    end
    else
    begin
      pin_prev_reg <= capture_input_pin_in;
      pin_primed_reg <= 1'b1;
      fifo_drop_out <= fifo_in_ready ? 4'h0 : edge_hit;
      capture_flag_out <= (fifo_out_valid ? fifo_out_data[3:0] : 4'h0);
      if (wr_en_in && (addr_in == `CFS_ADDR_CONTROL))
        capture_control_word_reg <= wr_data_in;
      if (capture_soft_clear)
      begin
        capture_store_status_reg <= 8'h00;
        for (j = 0; j < 4; j = j + 1)
        begin
          top_reg[j] <= 16'h0000;
          bottom_reg[j] <= 16'h0000;
        end
      end
      else
      begin
        for (j = 0; j < 4; j = j + 1)
        begin
          top_reg[j] <= top_next[j];
          bottom_reg[j] <= bottom_next[j];
          // A status write is dropped when a read or capture changes any fill level that cycle, so that update wins.
          capture_store_status_reg[2*j+1 -: 2] <= fill_next[j];
        end
        if (wr_en_in && (addr_in == `CFS_ADDR_STATUS))
          capture_store_status_reg <= (fill_next[3] == capture_store_status_reg[7:6] &&
            fill_next[2] == capture_store_status_reg[5:4] &&
            fill_next[1] == capture_store_status_reg[3:2] &&
            fill_next[0] == capture_store_status_reg[1:0]) ?
            ({fill_next[3], fill_next[2], fill_next[1], fill_next[0]} & ~wr_data_in[7:0]) :
            {fill_next[3], fill_next[2], fill_next[1], fill_next[0]};
      end
      rd_data_out <= 16'h0000;
      if (rd_en_in)
      begin
        case (addr_in)
          `CFS_ADDR_CONTROL: rd_data_out <= capture_control_word_reg;
          `CFS_ADDR_STATUS: rd_data_out <= {capture_store_status_reg, 8'h00};
          `CFS_ADDR_STORE1: rd_data_out <= top_reg[0];
          `CFS_ADDR_STORE2: rd_data_out <= top_reg[1];
          `CFS_ADDR_STORE3: rd_data_out <= top_reg[2];
          `CFS_ADDR_STORE4: rd_data_out <= top_reg[3];
          default: rd_data_out <= 16'h0000;
        endcase
      end
    end
  end
  // encodes fill levels via CFS_FILL constants above.
endmodule // cfs_capture_top
`default_nettype wire

// ---- test/cfs_timer_model.sv ----
/*
  Timer side model: two counter values that change only when loaded.
  Assumes the bench loads a value a cycle before the pin edge it wants stamped.
*/
`timescale 1ns/1ns
`default_nettype none
module cfs_timer_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic load_in,
  input wire logic [15:0] value_in,
  output logic [15:0] timer2_out,
  output logic [15:0] timer3_out
);
  // Held still between loads, so every snapshot has one known value.
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
      timer2_out <= 16'h0;
    else if (load_in)
      timer2_out <= value_in;
  assign timer3_out = ~timer2_out;
endmodule // cfs_timer_model
`default_nettype wire

// ---- test/cfs_capture_checker.sv ----
/*
  Assertions on the capture store top.
  Assumes one-cycle bus strobes on clk_in.
*/
`timescale 1ns/1ns
`default_nettype none
module cfs_capture_checker (
  input wire clk_in,
  input wire rst_in,
  input wire [15:0] addr_in,
  input wire wr_en_in,
  input wire rd_en_in,
  input wire [15:0] wr_data_in,
  input wire [15:0] rd_data_out,
  input wire [3:0] capture_flag_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  logic run_reg;
  wire st_rd = rd_en_in && addr_in == 16'h7422;
  wire s1_rd = rd_en_in && addr_in == 16'h7423;
  wire wr_ctl = wr_en_in && addr_in == 16'h7420;
  wire unm = rd_en_in && (addr_in < 16'h7420 || addr_in == 16'h7421 || addr_in > 16'h7426);
  // Shadow of the soft clear bit, since the control word is not watched otherwise.
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
      run_reg <= 1'b0;
    else if (wr_ctl)
      run_reg <= wr_data_in[15];
  sequence s_clr_rd;
    wr_en_in && addr_in == 16'h7422 && wr_data_in[7:0] == 8'hff ##1 st_rd && capture_flag_out == 4'h0;
  endsequence
  sequence s_soft_rd;
    wr_ctl && !wr_data_in[15] ##1 st_rd;
  endsequence
  sequence s_pop;
    st_rd ##1 s1_rd && rd_data_out[9:8] != 2'h0 && !capture_flag_out[0] ##1 st_rd && !capture_flag_out[0];
  endsequence
  sequence s_push;
    st_rd ##1 st_rd && capture_flag_out[0];
  endsequence
  AST_IDLE_ZERO: assert property (rd_data_out != 16'h0 |-> $past(rd_en_in)) else $error("data outside reply");
  AST_LOW_BYTE: assert property (st_rd |=> rd_data_out[7:0] == 8'h00) else $error("status low byte set");
  AST_UNMAPPED: assert property (unm |=> rd_data_out == 16'h0) else $error("unmapped read not zero");
  AST_RESET_ZERO: assert property ($fell(rst_in) |-> rd_data_out == 16'h0 && capture_flag_out == 4'h0)
    else $error("outputs set after reset");
  AST_SOFT_CLEAR: assert property (s_soft_rd |=> rd_data_out == 16'h0) else $error("soft clear left status");
  AST_HOLD_OFF: assert property ((!run_reg) [*4] |-> capture_flag_out == 4'h0) else $error("capture in clear");
  AST_CLEAR_BITS: assert property (s_clr_rd |=> rd_data_out[15:8] == 8'h00) else $error("status not cleared");
  AST_POP_LEVEL: assert property (s_pop |=> rd_data_out[9:8] == ($past(rd_data_out[9:8], 2) == 2'h1 ? 2'h0 : 2'h1))
    else $error("level after read wrong");
  AST_PUSH_LEVEL: assert property (s_push |=> rd_data_out[9:8] ==
    ($past(rd_data_out[9:8]) == 2'h3 ? 2'h3 : $past(rd_data_out[9:8]) + 2'h1)) else $error("level after capture wrong");
endmodule // cfs_capture_checker
bind cfs_capture_top cfs_capture_checker u_chk (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
  .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .wr_data_in(wr_data_in), .rd_data_out(rd_data_out),
  .capture_flag_out(capture_flag_out));
`default_nettype wire

// ---- test/tb.sv ----
/*
  Self-checking bench for the capture store top.
  Assumes the checker is bound and the timer model holds values between loads.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [15:0] addr_in = 16'h0;
  logic wr_en_in = 1'b0;
  logic rd_en_in = 1'b0;
  logic [15:0] wr_data_in = 16'h0;
  logic [3:0] pin = 4'h0;
  logic load = 1'b0;
  logic [15:0] load_val = 16'h0;
  wire [15:0] rd_data_out;
  wire [15:0] t2;
  wire [15:0] t3;
  wire [3:0] flag;
  wire [3:0] drop;
  logic [3:0] drop_seen = 4'h0;
  logic took = 1'b0;
  logic [16:0] exp_q[$];
  logic [16:0] e;
  logic [15:0] top[4];
  logic [15:0] bot[4];
  logic [1:0] lvl[4];
  logic [15:0] seed = 16'h9;
  int bad_count = 0;
  int n_compared = 0;
  cfs_capture_top dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_en_in(wr_en_in),
    .rd_en_in(rd_en_in), .wr_data_in(wr_data_in), .rd_data_out(rd_data_out), .capture_input_pin_in(pin),
    .timer2_count_in(t2), .timer3_count_in(t3), .capture_flag_out(flag), .fifo_drop_out(drop));
  cfs_timer_model tmr (.clk_in(clk_in), .rst_in(rst_in), .load_in(load), .value_in(load_val),
    .timer2_out(t2), .timer3_out(t3));
  initial forever #50 clk_in = ~clk_in;
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    n_compared++;
    if (seen !== want)
    begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  function automatic logic [15:0] xs(input logic [15:0] s);
    logic [15:0] x;
    x = s ^ (s << 7);
    x = x ^ (x >> 9);
    return x ^ (x << 8);
  endfunction
  // Bit 16 of a note marks a read whose answer races a capture.
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d, input logic [16:0] x);
    @(posedge clk_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_en_in <= w;
    rd_en_in <= !w;
    if (!w)
      exp_q.push_back(x);
  endtask
  function automatic logic [16:0] stat();
    return {1'b0, lvl[3], lvl[2], lvl[1], lvl[0], 8'h00};
  endfunction
  task automatic pop(input int c);
    acc(0, 16'h7423 + c[15:0], 16'h0, {1'b0, top[c]});
    if (lvl[c] > 2'h1)
      top[c] = bot[c];
    lvl[c] = (lvl[c] > 2'h1) ? 2'h1 : 2'h0;
  endtask
  task automatic tog(input int c, input logic hit);
    logic [15:0] v;
    seed = xs(seed);
    v = (c < 2) ? seed : ~seed;
    @(posedge clk_in);
    wr_en_in <= 1'b0;
    rd_en_in <= 1'b0;
    load <= 1'b1;
    load_val <= seed;
    @(posedge clk_in);
    load <= 1'b0;
    pin[c] <= !pin[c];
    repeat (6) acc(0, 16'h7422, 16'h0, 17'h10000);
    @(posedge clk_in);
    rd_en_in <= 1'b0;
    if (hit)
    begin
      if (lvl[c] == 2'h0)
        top[c] = v;
      else if (lvl[c] == 2'h1)
        bot[c] = v;
      else
      begin
        top[c] = bot[c];
        bot[c] = v;
      end
      lvl[c] = (lvl[c] == 2'h3) ? 2'h3 : lvl[c] + 2'h1;
    end
  endtask
  always @(posedge clk_in)
    took <= rd_en_in;
  always @(posedge clk_in)
    drop_seen <= drop_seen | drop;
  always @(negedge clk_in)
    if (took)
    begin
      e = exp_q.pop_front();
      if (!e[16])
        check(rd_data_out, e[15:0]);
    end
  initial
  begin
    repeat (20000) @(posedge clk_in);
    bad_count++;
    report_and_stop();
  end
  initial
  begin
    for (int i = 0; i < 4; i++)
    begin
      top[i] = 16'h0;
      bot[i] = 16'h0;
      lvl[i] = 2'h0;
    end
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    acc(0, 16'h7422, 16'h0, stat());
    acc(0, 16'h7421, 16'h0, 17'h0);
    acc(0, 16'h7427, 16'h0, 17'h0);
    tog(0, 1'b0);
    acc(1, 16'h7420, 16'hbc6c, 17'h0);
    for (int c = 0; c < 4; c++)
      repeat (6) tog(c, c == 2 || (c == 0 && !pin[0]) || (c == 1 && pin[1]));
    acc(1, 16'h7422, 16'hff01, 17'h0);
    lvl[0] = lvl[0] & 2'h2;
    for (int c = 0; c < 4; c++)
      repeat (3)
      begin
        acc(0, 16'h7422, 16'h0, stat());
        pop(c);
        acc(0, 16'h7422, 16'h0, stat());
      end
    acc(1, 16'h7420, 16'hac6c, 17'h0);
    tog(2, 1'b0);
    pop(2);
    repeat (4) tog(0, !pin[0]);
    acc(1, 16'h7422, 16'h00ff, 17'h0);
    acc(0, 16'h7422, 16'h0, 17'h0);
    lvl[0] = 2'h0;
    pop(0);
    acc(1, 16'h7420, 16'h0, 17'h0);
    acc(0, 16'h7422, 16'h0, 17'h0);
    acc(0, 16'h7423, 16'h0, 17'h0);
    tog(0, 1'b0);
    repeat (2) @(posedge clk_in);
    check({12'h000, drop_seen}, 16'h0000);
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
